// >>> rtl/codec_ctrl_pkg.sv
`default_nettype none
package codec_ctrl_pkg;

    // Control port command bytes
    localparam logic [7:0] CMD_DEACTIVATE  = 8'h00;
    localparam logic [7:0] CMD_SOFT_RESET  = 8'h02;
    localparam logic [7:0] CMD_NO_OP       = 8'h06;
    localparam logic [7:0] CMD_ACTIVATE    = 8'h0E;
    localparam logic [7:0] CMD_WR_RX_SLOT  = 8'h42;
    localparam logic [7:0] CMD_RD_RX_SLOT  = 8'h43;
    localparam logic [7:0] CMD_WR_CLK_SLOT = 8'h44;
    localparam logic [7:0] CMD_RD_CLK_SLOT = 8'h45;
    localparam logic [7:0] CMD_WR_SCALING  = 8'h50;
    localparam logic [7:0] CMD_RD_SCALING  = 8'h51;
    localparam logic [7:0] CMD_WR_OPER     = 8'h60;
    localparam logic [7:0] CMD_RD_OPER     = 8'h61;

    // Widths
    localparam int SLOT_W  = 7;
    localparam int CSLOT_W = 3;
    localparam int SCALE_W = 5;
    localparam int GAIN_W  = 6;
    localparam int POS_W   = 11;
    localparam int LIN_W   = 16;
    localparam int FIFO_W  = LIN_W + 1;
    localparam int FIFO_DEPTH = 8;
    localparam int SYNC_W  = 8;

    // Field positions in data bytes
    localparam int RX_PORT_BIT = 7;
    localparam int OPER_MU_BIT = 6;

    // Counts and codes
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [POS_W-1:0] BYTE_LAST = 11'h007;
    localparam logic [POS_W-1:0] POS_MAX = 11'h7FF;
    localparam logic [SCALE_W-1:0] SCALE_ZERO     = 5'h00;
    localparam logic [SCALE_W-1:0] SCALE_LOOPBACK = 5'h10;
    localparam logic [GAIN_W-1:0]  SCALE_OFFSET   = 6'h10;
    localparam logic [7:0]  ALAW_ABI_MASK = 8'h55;
    localparam logic [15:0] ALAW_HALF     = 16'h0008;
    localparam logic [15:0] ALAW_SEG_BASE = 16'h0100;
    localparam logic [15:0] MU_BIAS       = 16'h0084;

    // Reset values
    localparam logic [1:0] RESET_PORT_B = 2'h2;
    localparam logic [SYNC_W-1:0] SYNC_IDLE = 8'h60;

    typedef enum {ST_CMD, ST_WDATA, ST_RDATA} port_state_t;

endpackage
`default_nettype wire

// >>> rtl/bit_sync.sv
`default_nettype none
module bit_sync #(
    parameter int           W         = 1,
    parameter logic [W-1:0] RESET_VAL = '0
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         rst,
    // Asynchronous in, synchronous out
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_reg;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta_reg <= RESET_VAL;
            q        <= RESET_VAL;
        end else begin
            meta_reg <= d;
            q        <= meta_reg;
        end
    end
endmodule // bit_sync
`default_nettype wire

// >>> rtl/sample_fifo.sv
`default_nettype none
module sample_fifo #(
    parameter int W     = 8,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         rst,
    // Fill side
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    // Drain side
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic      [W-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [W-1:0] mem [DEPTH];
    logic [AW:0]  wr_ptr_reg;
    logic [AW:0]  rd_ptr_reg;
    logic         full;
    logic         empty;

    assign empty = (wr_ptr_reg == rd_ptr_reg);
    assign full  = (wr_ptr_reg[AW] != rd_ptr_reg[AW])
                && (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]);
    assign in_ready  = !full;
    assign out_valid = !empty;
    assign out_data  = mem[rd_ptr_reg[AW-1:0]];

    always_ff @(posedge clk) begin
        if (in_valid && !full) begin
            mem[wr_ptr_reg[AW-1:0]] <= in_data;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wr_ptr_reg <= '0;
        end else if (in_valid && !full) begin
            wr_ptr_reg <= wr_ptr_reg + 1'b1;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rd_ptr_reg <= '0;
        end else if (out_ready && !empty) begin
            rd_ptr_reg <= rd_ptr_reg + 1'b1;
        end
    end
endmodule // sample_fifo
`default_nettype wire

// >>> rtl/codec_serial_ctrl_rx_slot.sv
`default_nettype none
// How it works
// - Received highway bytes are expanded; bit positions count from frame sync.
// - Each channel holds a 7-bit receive time slot, up to 128 slots.
// - Slot logic works for any bit clock from 128 kHz to 8.192 MHz.
// - A 3-bit clock slot delays the slot start by 0 to 7 bits.
// - A slot running past the frame end never completes; host avoids it.
// - Each channel takes data from highway port A or B as programmed.
// - Scaling gain is code minus 16, in sixteenths.
// - Scaling code zero gives zero gain.
// - Scaling code 10000 disables scaling and loops output to input.
// - Operating-functions write selects A-law or mu-law companding.
// - A-law bytes get alternate bit inversion.
// - Both selects low applies a transfer to both channels.
// - Command bytes are 8 bits, followed by data in or out.
// - Bytes move most significant bit first in both directions.
// - A write command's data arrives in the next select-framed transfer.
// - After a read command, data goes out; incoming commands are ignored.
// - Unused bits of bytes sent out read as zero.
// - A select period without eight bits changes no setting, but ends a pending write or read.
// - With selects high, shift clock activity changes nothing.
// - Each select rising edge advances the byte sequence, except after a command byte of fewer than eight bits.
// - 00 deactivates, 02 resets, 06 does nothing, 0E activates.
// - Software reset affects only the selected channels.
// - Hardware reset: slots zero, channel 1 port A, channel 2 port B.
module codec_serial_ctrl_rx_slot
    import codec_ctrl_pkg::*;
(
    // Clock and reset
    input  wire logic                     mclk,
    input  wire logic                     sys_rst,
    // Host control port
    input  wire logic                     shift_clock,
    input  wire logic                     chan1_select_n,
    input  wire logic                     chan2_select_n,
    input  wire logic                     serial_bidir_in,
    output logic                          serial_bidir_out,
    output logic                          serial_bidir_oe,
    // Receive PCM highway
    input  wire logic                     pcm_bit_clock,
    input  wire logic                     frame_sync,
    input  wire logic                     pcm_rx_port_a,
    input  wire logic                     pcm_rx_port_b,
    // Expanded sample stream
    output logic                          sample_valid,
    input  wire logic                     sample_ready,
    output logic [LIN_W-1:0]              sample_data,
    output logic                          sample_chan,
    // Programmed state per channel
    output wire logic [1:0]               chan_active,
    output wire logic [1:0]               mu_law_sel,
    output wire logic [1:0]               rx_port_b_sel,
    output wire logic [1:0][SLOT_W-1:0]   rx_time_slot,
    output wire logic [1:0][CSLOT_W-1:0]  rx_clock_slot,
    output wire logic [1:0][SCALE_W-1:0]  scaling_code,
    output wire logic [1:0][GAIN_W-1:0]   impedance_scaling_gain,
    output wire logic [1:0]               analog_loopback
);

    // G.711 expansion to 16-bit linear
    function automatic logic [LIN_W-1:0] expand(input logic [7:0] code,
                                                input logic mu);
        logic [7:0]       x;
        logic [2:0]       e;
        logic [LIN_W-1:0] m;
        logic [LIN_W-1:0] mag;
        logic             neg;
        x   = mu ? ~code : (code ^ ALAW_ABI_MASK);
        e   = x[6:4];
        m   = {12'h000, x[3:0]};
        if (mu) begin
            mag = (((m << 3) + MU_BIAS) << e) - MU_BIAS;
            neg = x[7];
        end else begin
            mag = (m << 4) + ALAW_HALF;
            if (e != 3'h0) begin
                mag = (mag + ALAW_SEG_BASE) << (e - 3'h1);
            end
            neg = !x[7];
        end
        return neg ? (LIN_W'(0) - mag) : mag;
    endfunction

    // Input synchronisers
    logic [SYNC_W-1:0] sync_q;
    logic              sclk_s;
    logic [1:0]        sel_n_s;
    logic              din_s;
    logic              pclk_s;
    logic              fs_s;
    logic              pa_s;
    logic              pb_s;

    bit_sync #(
        .W         (SYNC_W),
        .RESET_VAL (SYNC_IDLE)
    ) u_sync (
        .clk (mclk),
        .rst (sys_rst),
        .d   ({shift_clock, chan2_select_n, chan1_select_n,
               serial_bidir_in, pcm_bit_clock, frame_sync,
               pcm_rx_port_a, pcm_rx_port_b}),
        .q   (sync_q)
    );

    assign {sclk_s, sel_n_s, din_s, pclk_s, fs_s, pa_s, pb_s} = sync_q;

    // Edge detection on synchronised levels
    logic       sclk_prev_reg;
    logic       any_low_prev_reg;
    logic       pclk_prev_reg;
    logic       any_low;
    logic       select_fall;
    logic       select_rise;
    logic       sclk_rise;
    logic       sclk_fall;
    logic       pclk_fall;

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            sclk_prev_reg    <= 1'b0;
            any_low_prev_reg <= 1'b0;
            pclk_prev_reg    <= 1'b0;
        end else begin
            sclk_prev_reg    <= sclk_s;
            any_low_prev_reg <= any_low;
            pclk_prev_reg    <= pclk_s;
        end
    end

    assign any_low     = !(&sel_n_s);
    assign select_fall = any_low && !any_low_prev_reg;
    assign select_rise = !any_low && any_low_prev_reg;
    assign sclk_rise   = sclk_s && !sclk_prev_reg && any_low;
    assign sclk_fall   = !sclk_s && sclk_prev_reg && any_low;
    assign pclk_fall   = !pclk_s && pclk_prev_reg;

    // Serial shifter
    logic [1:0] mask_reg;
    logic [3:0] bit_cnt_reg;
    logic [7:0] in_sr_reg;
    logic [7:0] out_sr_reg;
    logic       drive_reg;
    logic       byte_done;
    logic [1:0] rd_pending;
    logic [1:0][7:0] rd_val;
    logic       rd_pick;

    assign byte_done = select_rise && (bit_cnt_reg == BITS_PER_BYTE);
    assign rd_pick   = sel_n_s[0];

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            mask_reg <= 2'h0;
        end else if (select_fall) begin
            mask_reg <= ~sel_n_s;
        end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            bit_cnt_reg <= 4'h0;
            in_sr_reg   <= 8'h00;
        end else if (select_fall) begin
            bit_cnt_reg <= 4'h0;
        end else if (sclk_rise && bit_cnt_reg != BITS_PER_BYTE) begin
            in_sr_reg   <= {in_sr_reg[6:0], din_s};
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
        end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            out_sr_reg <= 8'h00;
            drive_reg  <= 1'b0;
        end else if (select_fall) begin
            out_sr_reg <= rd_val[rd_pick];
            drive_reg  <= rd_pending[rd_pick];
        end else if (select_rise) begin
            drive_reg  <= 1'b0;
        end else if (sclk_fall && bit_cnt_reg != 4'h0) begin
            out_sr_reg <= {out_sr_reg[6:0], 1'b0};
        end
    end

    assign serial_bidir_out = out_sr_reg[7];
    assign serial_bidir_oe  = drive_reg && any_low;

    // Receive frame position
    logic [POS_W-1:0] pos_reg;
    logic [POS_W-1:0] cur_pos;

    assign cur_pos = fs_s ? '0
                   : ((pos_reg == POS_MAX) ? POS_MAX : pos_reg + 11'h001);

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            pos_reg <= '0;
        end else if (pclk_fall) begin
            pos_reg <= cur_pos;
        end
    end

    // Per-channel state
    logic [1:0]      rx_pend;
    logic [1:0][7:0] rx_byte;
    logic            push_ch;
    logic            push_valid;
    logic            push_ready;

    assign push_ch    = !rx_pend[0];
    assign push_valid = |rx_pend;

    for (genvar g = 0; g < 2; g++) begin : chan
        port_state_t        state_reg;
        logic [7:0]         cmd_reg;
        logic               active_reg;
        logic               mu_reg;
        logic               port_b_reg;
        logic [SLOT_W-1:0]  slot_reg;
        logic [CSLOT_W-1:0] cslot_reg;
        logic [SCALE_W-1:0] code_reg;
        logic [GAIN_W-1:0]  gain_reg;
        logic [7:0]         pcm_sr_reg;
        logic [7:0]         byte_reg;
        logic               pend_reg;
        logic               take_now;
        logic               cmd_take;
        logic               data_take;
        logic [7:0]         rd_data;
        logic [POS_W-1:0]   start_pos;
        logic [POS_W-1:0]   idx;
        logic               in_slot;
        logic               cap_done;

        assign take_now  = select_rise && mask_reg[g];
        assign cmd_take  = take_now && byte_done && state_reg == ST_CMD;
        assign data_take = take_now && byte_done && state_reg == ST_WDATA;

        // Byte sequence per channel
        always_ff @(posedge mclk or posedge sys_rst) begin
            if (sys_rst) begin
                state_reg <= ST_CMD;
                cmd_reg   <= CMD_NO_OP;
            end else if (take_now) begin
                case (state_reg)
                    ST_CMD: begin
                        if (byte_done) begin
                            cmd_reg <= in_sr_reg;
                            case (in_sr_reg)
                                CMD_WR_RX_SLOT, CMD_WR_CLK_SLOT,
                                CMD_WR_SCALING, CMD_WR_OPER: begin
                                    state_reg <= ST_WDATA;
                                end
                                CMD_RD_RX_SLOT, CMD_RD_CLK_SLOT,
                                CMD_RD_SCALING, CMD_RD_OPER: begin
                                    state_reg <= ST_RDATA;
                                end
                                default: begin
                                    state_reg <= ST_CMD;
                                end
                            endcase
                        end
                    end
                    ST_WDATA: state_reg <= ST_CMD;
                    ST_RDATA: state_reg <= ST_CMD;
                    default:  state_reg <= ST_CMD;
                endcase
            end
        end

        // Programmed configuration
        always_ff @(posedge mclk or posedge sys_rst) begin
            if (sys_rst) begin
                active_reg <= 1'b0;
                mu_reg     <= 1'b0;
                port_b_reg <= RESET_PORT_B[g];
                slot_reg   <= '0;
                cslot_reg  <= '0;
                code_reg   <= SCALE_ZERO;
            end else if (cmd_take) begin
                case (in_sr_reg)
                    CMD_DEACTIVATE: active_reg <= 1'b0;
                    CMD_ACTIVATE:   active_reg <= 1'b1;
                    CMD_SOFT_RESET: begin
                        active_reg <= 1'b0;
                        mu_reg     <= 1'b0;
                        code_reg   <= SCALE_ZERO;
                    end
                    default: active_reg <= active_reg;
                endcase
            end else if (data_take) begin
                case (cmd_reg)
                    CMD_WR_RX_SLOT: begin
                        port_b_reg <= in_sr_reg[RX_PORT_BIT];
                        slot_reg   <= in_sr_reg[SLOT_W-1:0];
                    end
                    CMD_WR_CLK_SLOT: cslot_reg <= in_sr_reg[CSLOT_W-1:0];
                    CMD_WR_SCALING:  code_reg  <= in_sr_reg[SCALE_W-1:0];
                    CMD_WR_OPER:     mu_reg    <= in_sr_reg[OPER_MU_BIT];
                    default:         mu_reg    <= mu_reg;
                endcase
            end
        end

        // Scaling gain in sixteenths
        always_ff @(posedge mclk or posedge sys_rst) begin
            if (sys_rst) begin
                gain_reg <= '0;
            end else if (code_reg == SCALE_ZERO
                      || code_reg == SCALE_LOOPBACK) begin
                gain_reg <= '0;
            end else begin
                gain_reg <= {1'b0, code_reg} - SCALE_OFFSET;
            end
        end

        // Read-back with unused bits zero
        always_comb begin
            rd_data = 8'h00;
            case (cmd_reg)
                CMD_RD_RX_SLOT:  rd_data = {port_b_reg, slot_reg};
                CMD_RD_CLK_SLOT: rd_data[CSLOT_W-1:0] = cslot_reg;
                CMD_RD_SCALING:  rd_data[SCALE_W-1:0] = code_reg;
                CMD_RD_OPER:     rd_data[OPER_MU_BIT] = mu_reg;
                default:         rd_data = 8'h00;
            endcase
        end

        // Receive slot capture
        assign start_pos = {1'b0, slot_reg, 3'h0}
                         + {{(POS_W-CSLOT_W){1'b0}}, cslot_reg};
        assign idx       = cur_pos - start_pos;
        assign in_slot   = (cur_pos >= start_pos) && (idx <= BYTE_LAST);
        assign cap_done  = pclk_fall && active_reg && in_slot
                        && idx == BYTE_LAST;

        always_ff @(posedge mclk or posedge sys_rst) begin
            if (sys_rst) begin
                pcm_sr_reg <= 8'h00;
            end else if (pclk_fall && in_slot) begin
                pcm_sr_reg <= {pcm_sr_reg[6:0],
                               port_b_reg ? pb_s : pa_s};
            end
        end

        always_ff @(posedge mclk or posedge sys_rst) begin
            if (sys_rst) begin
                byte_reg <= 8'h00;
                pend_reg <= 1'b0;
            end else if (cap_done) begin
                byte_reg <= {pcm_sr_reg[6:0],
                             port_b_reg ? pb_s : pa_s};
                pend_reg <= 1'b1;
            end else if (push_ready && push_ch == g) begin
                pend_reg <= 1'b0;
            end
        end

        assign rd_pending[g]             = state_reg == ST_RDATA;
        assign rd_val[g]                 = rd_data;
        assign rx_pend[g]                = pend_reg;
        assign rx_byte[g]                = byte_reg;
        assign chan_active[g]            = active_reg;
        assign mu_law_sel[g]             = mu_reg;
        assign rx_port_b_sel[g]          = port_b_reg;
        assign rx_time_slot[g]           = slot_reg;
        assign rx_clock_slot[g]          = cslot_reg;
        assign scaling_code[g]           = code_reg;
        assign impedance_scaling_gain[g] = gain_reg;
        assign analog_loopback[g]        = code_reg == SCALE_LOOPBACK;
    end

    // Expanded samples buffered toward the user side
    logic fifo_in_ready;

    assign push_ready = push_valid && fifo_in_ready;

    sample_fifo #(
        .W     (FIFO_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk       (mclk),
        .rst       (sys_rst),
        .in_valid  (push_valid),
        .in_ready  (fifo_in_ready),
        .in_data   ({push_ch, expand(rx_byte[push_ch],
                                     mu_law_sel[push_ch])}),
        .out_valid (sample_valid),
        .out_ready (sample_ready),
        .out_data  ({sample_chan, sample_data})
    );

endmodule // codec_serial_ctrl_rx_slot
`default_nettype wire

// >>> tb/codec_ctrl_sva.sv
`default_nettype none
module codec_ctrl_sva
    import codec_ctrl_pkg::*;
(
    // Clock and reset
    input wire logic                    mclk,
    input wire logic                    sys_rst,
    // Host port
    input wire logic                    chan1_select_n,
    input wire logic                    chan2_select_n,
    input wire logic                    serial_bidir_oe,
    // Sample stream
    input wire logic                    sample_valid,
    input wire logic                    sample_ready,
    input wire logic [LIN_W-1:0]        sample_data,
    input wire logic                    sample_chan,
    // Programmed state
    input wire logic [1:0]              chan_active,
    input wire logic [1:0]              mu_law_sel,
    input wire logic [1:0]              rx_port_b_sel,
    input wire logic [1:0][SLOT_W-1:0]  rx_time_slot,
    input wire logic [1:0][CSLOT_W-1:0] rx_clock_slot,
    input wire logic [1:0][SCALE_W-1:0] scaling_code,
    input wire logic [1:0][GAIN_W-1:0]  impedance_scaling_gain,
    input wire logic [1:0]              analog_loopback
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);
    wire logic sel_any = !chan1_select_n || !chan2_select_n;
    sequence s_idle;
        (chan1_select_n && chan2_select_n) [*8];
    endsequence
    property p_quiet;
        s_idle |=> $stable(rx_time_slot) && $stable(scaling_code)
            && $stable(chan_active) && $stable(rx_clock_slot);
    endproperty
    property p_oe_off;
        (!sel_any) [*3] |-> !serial_bidir_oe;
    endproperty
    property p_oe_rise;
        $rose(serial_bidir_oe) |-> $past(sel_any, 2);
    endproperty
    property p_gain_zero;
        $stable(scaling_code[0]) && scaling_code[0] == SCALE_ZERO
            |-> impedance_scaling_gain[0] == '0;
    endproperty
    property p_gain_lin;
        $stable(scaling_code[0]) && scaling_code[0] != SCALE_ZERO
            && scaling_code[0] != SCALE_LOOPBACK |-> impedance_scaling_gain[0]
            == GAIN_W'({1'b0, scaling_code[0]} - SCALE_OFFSET);
    endproperty
    property p_loop;
        analog_loopback == {scaling_code[1] == SCALE_LOOPBACK,
                            scaling_code[0] == SCALE_LOOPBACK};
    endproperty
    property p_hold;
        sample_valid && !sample_ready |=> sample_valid
            && $stable(sample_data) && $stable(sample_chan);
    endproperty
    property p_rst;
        $fell(sys_rst) |-> rx_port_b_sel == RESET_PORT_B
            && rx_time_slot == '0 && rx_clock_slot == '0
            && chan_active == 2'h0 && mu_law_sel == 2'h0;
    endproperty
    a_quiet: assert property (p_quiet)
        else $error("state changed while deselected");
    a_oe_off: assert property (p_oe_off)
        else $error("data driven while deselected");
    a_oe_rise: assert property (p_oe_rise)
        else $error("drive began without select");
    a_gain_zero: assert property (p_gain_zero)
        else $error("zero code gain wrong");
    a_gain_lin: assert property (p_gain_lin)
        else $error("scaling gain wrong");
    a_loop: assert property (p_loop)
        else $error("loopback flag wrong");
    a_hold: assert property (p_hold)
        else $error("sample changed before taken");
    a_rst: assert property (p_rst)
        else $error("reset state wrong");
endmodule // codec_ctrl_sva
bind codec_serial_ctrl_rx_slot codec_ctrl_sva u_sva (.mclk, .sys_rst,
    .chan1_select_n, .chan2_select_n, .serial_bidir_oe, .sample_valid,
    .sample_ready, .sample_data, .sample_chan, .chan_active, .mu_law_sel,
    .rx_port_b_sel, .rx_time_slot, .rx_clock_slot, .scaling_code,
    .impedance_scaling_gain, .analog_loopback);
`default_nettype wire

// >>> tb/host_ctrl_model.sv
`default_nettype none
module host_ctrl_model (
    // Clock
    input  wire logic mclk,
    // Control lines
    output logic      shift_clock,
    output logic      chan1_select_n,
    output logic      chan2_select_n,
    output logic      host_data,
    input  wire logic line_data
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        {shift_clock, chan1_select_n, chan2_select_n, host_data} = 4'h6;
    end
    // One select-framed byte, nb bits, 80 ns shift clock
    task automatic xfer(input logic [1:0] sel_n, input logic [7:0] tx,
                        input int nb, output logic [7:0] rx);
        rx = '0;
        {chan2_select_n, chan1_select_n} <= sel_n;
        repeat (8) @(posedge mclk);
        for (int i = 7; i > 7 - nb; i--) begin
            host_data <= tx[i];
            repeat (4) @(posedge mclk);
            shift_clock <= 1'b1;
            repeat (4) @(posedge mclk);
            rx = {rx[6:0], line_data};
            shift_clock <= 1'b0;
        end
        repeat (4) @(posedge mclk);
        {chan2_select_n, chan1_select_n} <= 2'b11;
        host_data <= ~host_data;
        repeat (8) @(posedge mclk);
    endtask
endmodule // host_ctrl_model
`default_nettype wire

// >>> tb/tb.sv
`default_nettype none
module tb
    import codec_ctrl_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct packed {
        logic [1:0] s;
        logic [7:0] c;
        logic [7:0] d;
        logic [7:0] e;
    } row_t;
    localparam logic [31:0] FA = 32'h0035_4000;
    localparam logic [31:0] FB = 32'h0000_00FF;
    logic mclk = 0, sys_rst = 1, sample_ready = 0, host_data;
    logic shift_clock, chan1_select_n, chan2_select_n, serial_bidir_in;
    logic serial_bidir_out, serial_bidir_oe, sample_valid, sample_chan;
    logic pcm_bit_clock = 0, frame_sync = 0;
    logic pcm_rx_port_a = 0, pcm_rx_port_b = 0;
    logic [LIN_W-1:0] sample_data;
    logic [1:0] chan_active, mu_law_sel, rx_port_b_sel, analog_loopback;
    logic [1:0][SLOT_W-1:0] rx_time_slot;
    logic [1:0][CSLOT_W-1:0] rx_clock_slot;
    logic [1:0][SCALE_W-1:0] scaling_code;
    logic [1:0][GAIN_W-1:0] impedance_scaling_gain;
    logic [7:0] pc = 8'h00, rd;
    int err_total = 0, cmp_count = 0, n_smp = 0;
    row_t rows [7] = '{
        '{2'b10, CMD_WR_RX_SLOT, 8'h01, 8'h01},
        '{2'b01, CMD_WR_RX_SLOT, 8'h83, 8'h83},
        '{2'b10, CMD_WR_CLK_SLOT, 8'h02, 8'h02},
        '{2'b01, CMD_WR_CLK_SLOT, 8'hF8, 8'h00},
        '{2'b10, CMD_WR_SCALING, 8'h1F, 8'h1F},
        '{2'b10, CMD_WR_SCALING, 8'h10, 8'h10},
        '{2'b01, CMD_WR_OPER, 8'h40, 8'h40}};
    assign serial_bidir_in = serial_bidir_oe ? serial_bidir_out : host_data;
    always #5 mclk = ~mclk;
    host_ctrl_model u_host (.mclk, .shift_clock, .chan1_select_n,
        .chan2_select_n, .host_data, .line_data(serial_bidir_in));
    codec_serial_ctrl_rx_slot uut (.mclk, .sys_rst, .shift_clock,
        .chan1_select_n, .chan2_select_n, .serial_bidir_in, .serial_bidir_out,
        .serial_bidir_oe, .pcm_bit_clock, .frame_sync, .pcm_rx_port_a,
        .pcm_rx_port_b, .sample_valid, .sample_ready, .sample_data,
        .sample_chan, .chan_active, .mu_law_sel, .rx_port_b_sel, .rx_time_slot,
        .rx_clock_slot, .scaling_code, .impedance_scaling_gain,
        .analog_loopback);
    // 32-bit frame, 80 ns bit clock, data changes on rising edge
    always @(posedge mclk) begin
        pc <= pc + 8'h01;
        pcm_bit_clock <= ~pc[2];
        frame_sync <= (pc[7:3] == 5'h00);
        pcm_rx_port_a <= FA[5'd31 - pc[7:3]];
        pcm_rx_port_b <= FB[5'd31 - pc[7:3]];
    end
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        cmp_count++;
        if (g !== e) begin
            err_total++;
            $display("ERROR %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic conclude;
        $display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    always @(posedge mclk) begin
        if (sample_valid === 1'b1 && sample_ready === 1'b1) begin
            n_smp <= n_smp + 1;
            if (sample_chan === 1'b0)
                chk(sample_data, 16'h0008);
            else
                chk(sample_data, 16'h0000);
        end
    end
    initial begin
        repeat (16) @(posedge mclk);
        sys_rst <= 1'b0;
        repeat (4) @(posedge mclk);
        chk(rx_port_b_sel, 16'h0002);
        foreach (rows[i]) begin
            u_host.xfer(rows[i].s, rows[i].c, 8, rd);
            u_host.xfer(rows[i].s, rows[i].d, 8, rd);
            u_host.xfer(rows[i].s, rows[i].c + 8'h01, 8, rd);
            u_host.xfer(rows[i].s, CMD_ACTIVATE, 8, rd);
            chk(rd, rows[i].e);
        end
        chk(chan_active, 16'h0000);
        u_host.xfer(2'b00, CMD_WR_SCALING, 8, rd);
        u_host.xfer(2'b00, 8'h05, 8, rd);
        chk(scaling_code, 16'h00A5);
        u_host.xfer(2'b10, CMD_ACTIVATE, 5, rd);
        chk(chan_active, 16'h0000);
        u_host.xfer(2'b00, CMD_ACTIVATE, 8, rd);
        chk(chan_active, 16'h0003);
        // FIFO fills while stalled, then drains
        repeat (1536) @(posedge mclk);
        sample_ready <= 1'b1;
        repeat (512) @(posedge mclk);
        chk(16'(n_smp >= 8), 16'h0001);
        u_host.xfer(2'b00, CMD_DEACTIVATE, 8, rd);
        chk(chan_active, 16'h0000);
        repeat (512) @(posedge mclk);
        u_host.xfer(2'b01, CMD_SOFT_RESET, 8, rd);
        u_host.xfer(2'b01, CMD_NO_OP, 8, rd);
        chk(scaling_code, 16'h0005);
        chk(mu_law_sel, 16'h0000);
        conclude();
    end
endmodule // tb
`default_nettype wire
